// *** pkg/rdp_pkg.sv ***
// rom data fix unit: shared constants and carrier types
// assumes a single ahb-lite master and 32-bit word accesses only
`default_nettype none

package rdp_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int          NUM_ENTRIES  = 8;    // fix entries
  localparam int          DATA_W       = 32;   // word width
  localparam int          OFS_W        = 10;   // offset bits in window

  // ---------------------------------------------------------------
  // address windows
  // ---------------------------------------------------------------
  localparam logic [31:0] REG_BASE     = 32'h4000_8400; // register window
  localparam logic [31:0] REG_LAST     = 32'h4000_87FF; // window end
  localparam logic [31:0] ROM_FIRST    = 32'h0000_0000; // rom region start
  localparam logic [31:0] ROM_LAST     = 32'h0001_4FFF; // rom region end

  // ---------------------------------------------------------------
  // register offsets within the window
  // ---------------------------------------------------------------
  localparam logic [9:0]  OFS_ENTRY_LO = 10'h000; // first pair
  localparam logic [9:0]  OFS_ENTRY_HI = 10'h03C; // last word of pairs
  localparam logic [9:0]  OFS_VALID    = 10'h040; // fix_entry_valid
  localparam logic [9:0]  OFS_CLEAR    = 10'h044; // fix_valid_clear
  localparam logic [9:0]  OFS_SET      = 10'h048; // fix_valid_set
  localparam int          PAIR_LSB     = 3;       // entry index lsb
  localparam int          DATA_SEL_BIT = 2;       // 0 addr, 1 data

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  VALID_RST    = 8'h00;
  localparam logic [31:0] WORD_RST     = 32'h0000_0000;
  localparam logic        HREADY_RST   = 1'b1;
  localparam logic        HRESP_OKAY   = 1'b0;

  // ---------------------------------------------------------------
  // carrier: register access captured in the address phase
  // ---------------------------------------------------------------
  typedef struct packed {
    logic             wr;   // write pending in data phase
    logic             rd;   // read pending in data phase
    logic [OFS_W-1:0] ofs;  // byte offset in window
  } rdp_req_s;

  // carrier: rom read captured in the address phase
  typedef struct packed {
    logic              pend; // rom data phase outstanding
    logic              hit;  // an enabled entry matched
    logic [DATA_W-1:0] word; // replacement word of winner
  } rdp_rom_s;

endpackage : rdp_pkg

`default_nettype wire

// *** rtl/rdp_fix_unit.sv ***
// rom data fix unit: register slave plus read-data substitution
// assumes ahb-lite timing, word accesses, one master, clk is hclk
`default_nettype none

// How it works
// - eight entries, address and replacement word pairs
// - address then data written sets that entry's valid bit
// - parallel compare, matching enabled entry replaces data
// - highest matching entry index wins
// - one in clear register disables entry
// - one in set register re-enables entry
// - bus clock; software reprograms after power-up
// - registers answer only inside their window
// - substitution only on rom region reads
module rdp_fix_unit
  import rdp_pkg::*;
(
  input  wire logic              clk,            // bus clock
  input  wire logic              rst,            // async reset, high
  input  wire logic              ce,             // clock enable
  input  wire logic              hsel,           // register select
  input  wire logic              rom_sel,        // rom controller select
  input  wire logic [31:0]       haddr,          // ahb address
  input  wire logic [1:0]        htrans,         // ahb transfer type
  input  wire logic              hwrite,         // ahb write
  input  wire logic [DATA_W-1:0] hwdata,         // ahb write data
  input  wire logic              hready,         // ahb bus ready
  input  wire logic [DATA_W-1:0] rom_rdata,      // raw rom read data
  output logic                   hreadyout,      // register slave ready
  output logic                   hresp,          // register slave resp
  output logic [DATA_W-1:0]      hrdata,         // register read data
  output logic [DATA_W-1:0]      fix_rdata,      // rom data after fix
  output logic                   fix_rdata_valid // fix_rdata strobe
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  rdp_req_s          req, next_req;          // register access
  rdp_rom_s          rom, next_rom;          // rom read in flight
  logic [DATA_W-1:0] next_hrdata;            // read data to register
  logic [DATA_W-1:0] next_fix_rdata;         // fixed rom data
  logic              next_fix_rdata_valid;   // fixed data strobe
  logic [DATA_W-1:0] match_addr [NUM_ENTRIES]; // fix_match_addr_x
  logic [DATA_W-1:0] repl_data  [NUM_ENTRIES]; // fix_repl_data_x
  logic [DATA_W-1:0] next_match_addr [NUM_ENTRIES];
  logic [DATA_W-1:0] next_repl_data  [NUM_ENTRIES];
  logic [NUM_ENTRIES-1:0] valid, next_valid; // fix_entry_valid
  logic [NUM_ENTRIES-1:0] armed, next_armed; // address half written
  logic [NUM_ENTRIES-1:0] hit_vec;           // per-entry compare
  logic              in_window;              // haddr inside window
  logic              in_rom;                 // haddr inside rom
  logic              wr_pair;                // write hits a pair word
  logic              wr_clear;               // write to clear reg
  logic              wr_set;                 // write to set reg
  logic [2:0]        wr_idx;                 // entry of pair write

  // ---------------------------------------------------------------
  // register access decode
  // ---------------------------------------------------------------
  // address window check, both bounds
  assign in_window = (haddr >= REG_BASE) && (haddr <= REG_LAST);
  // rom region starts at zero so only the top bound needs checking
  assign in_rom    = (haddr <= ROM_LAST);

  assign wr_pair  = req.wr && (req.ofs <= OFS_ENTRY_HI);
  assign wr_clear = req.wr && (req.ofs == OFS_CLEAR);
  assign wr_set   = req.wr && (req.ofs == OFS_SET);
  assign wr_idx   = req.ofs[PAIR_LSB +: 3];

  // ---------------------------------------------------------------
  // per-entry storage and valid bit
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_ENTRIES; i++) begin : g_entry
    logic wr_a;  // this entry's match address written
    logic wr_d;  // this entry's replacement word written
    logic set_v; // valid to be set
    logic clr_v; // valid to be cleared

    // next values of one entry
    always_comb begin
      wr_a  = wr_pair && (wr_idx == 3'(i)) && !req.ofs[DATA_SEL_BIT];
      wr_d  = wr_pair && (wr_idx == 3'(i)) &&  req.ofs[DATA_SEL_BIT];
      next_match_addr[i] = wr_a ? hwdata : match_addr[i];
      next_repl_data[i]  = wr_d ? hwdata : repl_data[i];
      // address must come first; the data write completes the pair
      set_v = (wr_d && armed[i]) ||
              (wr_set && hwdata[i]);
      clr_v = wr_clear && hwdata[i];
      // a set in the same cycle as a clear wins
      if (set_v) begin
        next_valid[i] = 1'b1;
      end else if (clr_v) begin
        next_valid[i] = 1'b0;
      end else begin
        next_valid[i] = valid[i];
      end
      if (wr_a) begin
        next_armed[i] = 1'b1;
      end else if (wr_d) begin
        next_armed[i] = 1'b0;
      end else begin
        next_armed[i] = armed[i];
      end
    end

    // entry registers; contents are lost with the power domain
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        match_addr[i] <= WORD_RST;
        repl_data[i]  <= WORD_RST;
        valid[i]      <= VALID_RST[i];
        armed[i]      <= 1'b0;
      end else if (ce) begin
        match_addr[i] <= next_match_addr[i];
        repl_data[i]  <= next_repl_data[i];
        valid[i]      <= next_valid[i];
        armed[i]      <= next_armed[i];
      end
    end

    // comparator, all entries in parallel
    assign hit_vec[i] = valid[i] && (match_addr[i] == haddr);
  end

  // ---------------------------------------------------------------
  // register slave: address phase capture and read data
  // ---------------------------------------------------------------
  // reads return the values after any write now in its data phase,
  // so a read straight after a write sees the new value
  always_comb begin
    next_req     = '0;
    next_hrdata  = WORD_RST;
    if (hsel && hready && htrans[1] && in_window) begin
      next_req.wr  = hwrite;
      next_req.rd  = !hwrite;
      next_req.ofs = haddr[OFS_W-1:0];
    end
    if (next_req.rd) begin
      if (next_req.ofs <= OFS_ENTRY_HI) begin
        // pair words; index from the offset
        if (next_req.ofs[DATA_SEL_BIT]) begin
          next_hrdata = next_repl_data[next_req.ofs[PAIR_LSB +: 3]];
        end else begin
          next_hrdata = next_match_addr[next_req.ofs[PAIR_LSB +: 3]];
        end
      end else if (next_req.ofs == OFS_VALID) begin
        next_hrdata = {24'h00_0000, next_valid};
      end else begin
        // clear, set and unmapped offsets read as zero
        next_hrdata = WORD_RST;
      end
    end
  end

  // register slave flops; zero wait states, always okay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req       <= '0;
      hrdata    <= WORD_RST;
      hreadyout <= HREADY_RST;
      hresp     <= HRESP_OKAY;
    end else if (ce) begin
      req       <= next_req;
      hrdata    <= next_hrdata;
      hreadyout <= HREADY_RST;
      hresp     <= HRESP_OKAY;
    end
  end

  // ---------------------------------------------------------------
  // rom read path: select winner, then substitute in data phase
  // ---------------------------------------------------------------
  always_comb begin
    next_rom             = rom;
    next_fix_rdata       = fix_rdata;
    next_fix_rdata_valid = 1'b0;
    if (hready) begin
      // data phase of the previous rom read completes now
      if (rom.pend) begin
        next_fix_rdata_valid = 1'b1;
        next_fix_rdata = rom.hit ? rom.word : rom_rdata;
      end
      next_rom = '0;
      if (rom_sel && htrans[1] && !hwrite && in_rom) begin
        next_rom.pend = 1'b1;
        // ascending scan, so the last match is the highest index
        for (int k = 0; k < NUM_ENTRIES; k++) begin
          if (hit_vec[k]) begin
            next_rom.hit  = 1'b1;
            next_rom.word = repl_data[k];
          end
        end
      end else if (rom_sel && htrans[1] && !hwrite) begin
        next_rom.pend = 1'b1;
      end
    end
  end

  // rom path flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rom             <= '0;
      fix_rdata       <= WORD_RST;
      fix_rdata_valid <= 1'b0;
    end else if (ce) begin
      rom             <= next_rom;
      fix_rdata       <= next_fix_rdata;
      fix_rdata_valid <= next_fix_rdata_valid;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_pair_store;
    ce && wr_pair && !req.ofs[DATA_SEL_BIT] |=>
      match_addr[$past(wr_idx)] == $past(hwdata);
  endproperty
  a_pair_store: assert property (p_pair_store)
    else $error("match address not stored");

  property p_auto_valid;
    ce && wr_pair && req.ofs[DATA_SEL_BIT] && armed[wr_idx] |=>
      valid[$past(wr_idx)];
  endproperty
  a_auto_valid: assert property (p_auto_valid)
    else $error("entry not valid after pair written");

  property p_hit_sub;
    ce && hready && rom.pend && rom.hit |=>
      fix_rdata_valid && fix_rdata == $past(rom.word);
  endproperty
  a_hit_sub: assert property (p_hit_sub)
    else $error("replacement word not substituted");

  property p_top_wins;
    ce && hready && rom_sel && htrans[1] && !hwrite && in_rom &&
      hit_vec[7] |=> rom.hit && rom.word == $past(repl_data[7]);
  endproperty
  a_top_wins: assert property (p_top_wins)
    else $error("highest entry did not win");

  property p_clear;
    ce && wr_clear && !wr_set |=>
      valid == ($past(valid) & ~$past(hwdata[7:0]));
  endproperty
  a_clear: assert property (p_clear)
    else $error("valid clear wrong");

  property p_set;
    ce && wr_set |=> (valid & $past(hwdata[7:0])) == $past(hwdata[7:0]);
  endproperty
  a_set: assert property (p_set)
    else $error("valid set wrong");

  // all-zero set or clear words must leave every valid bit alone
  property p_zero_noop;
    ce && (wr_set || wr_clear) && hwdata[7:0] == 8'h00 |=>
      valid == $past(valid);
  endproperty
  a_zero_noop: assert property (p_zero_noop)
    else $error("zero write changed valid bits");

  property p_window;
    ce && hsel && hready && htrans[1] && !in_window |=> !req.wr && !req.rd;
  endproperty
  a_window: assert property (p_window)
    else $error("access outside window taken");

  property p_no_rom;
    ce && hready && rom_sel && htrans[1] && !hwrite && !in_rom |=>
      ##1 (!fix_rdata_valid || !hready || fix_rdata == $past(rom_rdata));
  endproperty
  a_no_rom: assert property (p_no_rom)
    else $error("substitution outside rom region");

  property p_pass;
    ce && hready && rom.pend && !rom.hit |=> fix_rdata == $past(rom_rdata);
  endproperty
  a_pass: assert property (p_pass)
    else $error("rom data not passed unchanged");

  property p_okay;
    hreadyout && hresp == HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay)
    else $error("slave response not okay");

  c_hit:    cover property (ce && hready && rom.pend && rom.hit);
  c_multi:  cover property ($countones(hit_vec) > 1);
  c_clear:  cover property (ce && wr_clear && hwdata[0]);
  c_reread: cover property (ce && req.wr ##1 req.rd);

endmodule : rdp_fix_unit

`default_nettype wire

// *** testbench/rdp_rom_model.sv ***
// rom controller model: answers each rom read with its address xor 5A5A_0F0F
// assumes zero wait states and the ahb-lite address/data pipeline
`default_nettype none

module rdp_rom_model
  import rdp_pkg::*;
(
  input  wire logic              clk,      // bus clock
  input  wire logic              rst,      // async reset, high
  input  wire logic              rom_sel,  // rom select
  input  wire logic [31:0]       haddr,    // ahb address
  input  wire logic [1:0]        htrans,   // transfer type
  input  wire logic              hwrite,   // write flag
  input  wire logic              hready,   // bus ready
  output logic      [DATA_W-1:0] rom_rdata // raw rom data
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // data phase
  // ---------------------------------------------------------------
  // word shown in the data phase of a read, else the inverse of the
  // last word so stale data never looks valid
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rom_rdata <= 32'h0000_0000;
    end else if (hready && rom_sel && htrans[1] && !hwrite) begin
      rom_rdata <= haddr ^ 32'h5A5A_0F0F;
    end else begin
      rom_rdata <= ~rom_rdata;
    end
  end
endmodule : rdp_rom_model

`default_nettype wire

// *** testbench/rom_data_patch_unit_tb_top.sv ***
// testbench for the rom data fix unit: register and rom read tasks
// assumes zero wait state design and the rom model beside it
`default_nettype none

module rom_data_patch_unit_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rdp_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [31:0] ENT = REG_BASE;              // entry 0
  localparam logic [31:0] VLD = REG_BASE + 32'h40;     // valid bits
  localparam logic [31:0] CLR = REG_BASE + 32'h44;     // clear bits
  localparam logic [31:0] SET = REG_BASE + 32'h48;     // set bits
  logic        clk, rst, ce, hsel, rom_sel, hwrite, hready;
  logic [31:0] haddr, hwdata, rom_rdata, hrdata, fix_rdata;
  logic [1:0]  htrans;
  logic        hreadyout, hresp, fix_rdata_valid;
  int          err_total, n_tests, cyc, i;

  rdp_fix_unit u_dut (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel),
    .rom_sel(rom_sel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .rom_rdata(rom_rdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .fix_rdata(fix_rdata), .fix_rdata_valid(fix_rdata_valid));

  rdp_rom_model u_rom (.clk(clk), .rst(rst), .rom_sel(rom_sel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .rom_rdata(rom_rdata));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // expected raw rom word for an address
  function automatic logic [31:0] raw(input logic [31:0] a);
    return a ^ 32'h5A5A_0F0F;
  endfunction : raw

  // compare one word and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // register write: address phase, then data phase
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
  endtask : wr

  // register read: data is looked at in the data phase
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    #1;
    chk(hrdata, exp);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    @(posedge clk);
  endtask : rd

  // rom read: result pulses one cycle after the rom data phase
  task automatic rom(input logic [31:0] a, input logic [31:0] exp);
    rom_sel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    @(posedge clk);
    rom_sel <= 1'b0;
    htrans <= 2'h0;
    #1;
    chk({31'h0, fix_rdata_valid}, 32'h0);
    @(posedge clk);
    #1;
    chk({31'h0, fix_rdata_valid}, 32'h1);
    chk(fix_rdata, exp);
    @(posedge clk);
  endtask : rom

  // verdict and end of run
  task automatic tally_and_finish;
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------
  // clock and timeout
  // ---------------------------------------------------------------
  always #2 clk = ~clk;

  // cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish;
    end
  end

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    {clk, ce, hready, rst} = 4'h7;
    {hsel, rom_sel, hwrite, htrans} = 5'h00;
    {haddr, hwdata} = 64'h0;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(VLD, 32'h0);
    rom(32'h100, raw(32'h100));
    // entries in pairs share one address; address goes first
    for (i = 0; i < 8; i++) begin
      wr(ENT + 32'(8 * i), 32'h100 + 32'(4 * (i / 2)));
      rd(VLD, 32'(2 ** i - 1));
      wr(ENT + 32'(8 * i + 4), 32'hC0DE_0000 + 32'(i));
      rd(VLD, 32'(2 ** (i + 1) - 1));
      rd(ENT + 32'(8 * i + 4), 32'hC0DE_0000 + 32'(i));
    end
    for (i = 0; i < 4; i++) begin
      rom(32'h100 + 32'(4 * i), 32'hC0DE_0001 + 32'(2 * i));
    end
    wr(CLR, 32'h0);
    wr(VLD, 32'h0);
    rd(VLD, 32'hFF);
    wr(CLR, 32'h02);
    rd(VLD, 32'hFD);
    rom(32'h100, 32'hC0DE_0000);
    wr(CLR, 32'h01);
    rom(32'h100, raw(32'h100));
    wr(SET, 32'h0);
    rd(VLD, 32'hFC);
    wr(SET, 32'h02);
    rom(32'h100, 32'hC0DE_0001);
    // rom region edge and beyond
    wr(ENT + 32'h28, 32'h0001_4FFC);
    wr(ENT + 32'h30, 32'h0001_5000);
    rom(32'h0001_4FFC, 32'hC0DE_0005);
    rom(32'h0001_5000, raw(32'h0001_5000));
    // register window upper bound and an unmapped offset
    wr(REG_BASE + 32'h400, 32'hDEAD_BEEF);
    rd(ENT, 32'h100);
    rd(REG_BASE + 32'h50, 32'h0);
    // clock enable low freezes all state, so this clear is lost
    ce <= 1'b0;
    wr(CLR, 32'hFF);
    ce <= 1'b1;
    rd(VLD, 32'hFE);
    // reset in mid-run loses all entries
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(VLD, 32'h0);
    rom(32'h104, raw(32'h104));
    tally_and_finish;
  end
endmodule : rom_data_patch_unit_tb_top

`default_nettype wire
